//--- shared/ecg_spi_pkg.sv
// Constants for the ECG frame serial readout block
package ecg_spi_pkg;
    // Register addresses
    localparam logic [6:0] ADDR_NOP = 7'h00;
    localparam logic [6:0] ADDR_CTL = 7'h01;
    localparam logic [6:0] ADDR_GPIO = 7'h06;
    localparam logic [6:0] ADDR_FRM = 7'h0a;
    localparam logic [6:0] ADDR_CH1 = 7'h11;
    localparam logic [6:0] ADDR_CH2 = 7'h12;
    localparam logic [6:0] ADDR_CH3 = 7'h13;
    localparam logic [6:0] ADDR_PACE = 7'h1a;
    localparam logic [6:0] ADDR_RESP_MAG = 7'h1b;
    localparam logic [6:0] ADDR_RESP_PHASE = 7'h1c;
    localparam logic [6:0] ADDR_LEAD_OFF = 7'h1d;
    localparam logic [6:0] ADDR_HDR = 7'h40;
    localparam logic [6:0] ADDR_CRC = 7'h41;
    // Field positions
    localparam int CMD_RW_BIT = 31;
    localparam int CTL_CNV_BIT = 2;
    localparam int CTL_SPEED_BIT = 3;
    localparam int FRM_SKIP_LSB = 0;
    localparam int FRM_RATE_LSB = 4;
    localparam int FRM_RPT_BIT = 6;
    localparam int FRM_OMIT_LSB = 14;
    localparam int HDR_READY_BIT = 22;
    // Reset values
    localparam logic [23:0] CTL_RST = 24'h000000;
    localparam logic [23:0] FRM_RST = 24'h000000;
    localparam logic [23:0] GPIO_RST = 24'h000000;
    // Frame shapes
    localparam logic [1:0] RATE_128K = 2'h2;
    localparam logic [5:0] WLEN_CMD = 6'h20;
    localparam logic [5:0] WLEN_FAST = 6'h10;
    localparam logic [3:0] SLOTS_32 = 4'ha;
    localparam logic [3:0] SLOTS_16 = 4'hd;
    // Timing
    localparam int CORE_CLK_HZ = 20000000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int MCLK_HP_HZ = 2048000;
    localparam int MCLK_LP_HZ = 1024000;
    localparam int HS_MCLK_CYCLES = 3;
    localparam logic [6:0] HS_HP_CYC =
        7'((HS_MCLK_CYCLES * CORE_CLK_HZ + MCLK_HP_HZ - 1) / MCLK_HP_HZ);
    localparam logic [6:0] HS_LP_CYC =
        7'((HS_MCLK_CYCLES * CORE_CLK_HZ + MCLK_LP_HZ - 1) / MCLK_LP_HZ);
    localparam int INIT_TIME_NS = 3200;
    localparam logic [6:0] INIT_CYC =
        7'((INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : ecg_spi_pkg

//--- src/ecg_frame_spi_readout.sv
// Serial command decoding and frame streaming for the ECG front end
`timescale 1ns/100ps
module ecg_frame_spi_readout
    import ecg_spi_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    output logic frame_ready_n,
    output logic conversion_enable,
    input wire logic frame_load,
    input wire logic [23:0] ecg_ch1_data,
    input wire logic [23:0] ecg_ch2_data,
    input wire logic [23:0] ecg_ch3_data,
    input wire logic [23:0] pace_data,
    input wire logic [23:0] resp_mag_data,
    input wire logic [23:0] resp_phase_data,
    input wire logic [23:0] lead_off_data,
    input wire logic [23:0] checksum_data
);

    typedef struct packed {
        logic cs_s1, cs_s2, ck_s1, ck_s2, ck_s3, di_s1, di_s2, init_done, full;
        logic [6:0] init_cnt, wr_addr, hs_cnt;
        logic [23:0] ctl, frm, gpio, wr_data;
        logic [8:0][23:0] bufv;
        logic [3:0] skip_cnt, pos;
        logic [31:0] rx, tx, resp;
        logic [5:0] rcnt, fcnt, wlen;
        logic tx_act, framing, last, resp_pend, wr_req, wr_arm, sdo, sdo_oe, rdy_n;
    } state_t;

    state_t s_q, s_d;
    logic ck_rise, ck_fall, word_end, r128;
    logic [31:0] rx_word;
    logic [6:0] hs_need;
    // Frame slot to source word: slots 4 to 9 pair up at 128 kHz
    function automatic logic [3:0] slot_word(input logic [3:0] slot, input logic fast);
        logic [3:0] w;
        w = slot;
        if (fast) begin
            case (slot)
                4'h4, 4'h5: w = 4'h4;
                4'h6, 4'h7: w = 4'h5;
                4'h8, 4'h9: w = 4'h6;
                4'ha: w = 4'h7;
                4'hb: w = 4'h8;
                4'hc: w = 4'h9;
                default: w = slot;
            endcase
        end
        return w;
    endfunction : slot_word
    // Address that tags each frame word
    function automatic logic [6:0] word_addr(input logic [3:0] w);
        logic [6:0] a;
        case (w)
            4'h0: a = ADDR_HDR;
            4'h1: a = ADDR_CH1;
            4'h2: a = ADDR_CH2;
            4'h3: a = ADDR_CH3;
            4'h4: a = ADDR_PACE;
            4'h5: a = ADDR_RESP_MAG;
            4'h6: a = ADDR_RESP_PHASE;
            4'h7: a = ADDR_LEAD_OFF;
            4'h8: a = ADDR_GPIO;
            default: a = ADDR_CRC;
        endcase
        return a;
    endfunction : word_addr
    // First included slot at or after a position; bit 4 flags a hit
    function automatic logic [4:0] next_slot(input logic [3:0] from, input logic fast,
                                             input logic [9:0] omit);
        logic [4:0] res;
        logic [3:0] lim;
        res = 5'h00;
        lim = fast ? SLOTS_16 : SLOTS_32;
        for (int i = 12; i >= 0; i--) begin
            if (4'(i) >= from && 4'(i) < lim && !omit[slot_word(4'(i), fast)]) begin
                res = {1'b1, 4'(i)};
            end
        end
        return res;
    endfunction : next_slot
    // Data of a frame word; the header carries the ready bit
    function automatic logic [23:0] word_data(input state_t s, input logic [3:0] w);
        logic [23:0] d;
        d = 24'h000000;
        if (w == 4'h0) begin
            d[HDR_READY_BIT] = s.full;
        end else begin
            d = s.bufv[w - 4'h1];
        end
        return d;
    endfunction : word_data
    // Register readback
    function automatic logic [23:0] rd_reg(input state_t s, input logic [6:0] a);
        logic [23:0] d;
        case (a)
            ADDR_CTL: d = s.ctl;
            ADDR_FRM: d = s.frm;
            ADDR_GPIO: d = s.gpio;
            ADDR_HDR: d = word_data(s, 4'h0);
            ADDR_CH1: d = s.bufv[0];
            ADDR_CH2: d = s.bufv[1];
            ADDR_CH3: d = s.bufv[2];
            ADDR_PACE: d = s.bufv[3];
            ADDR_RESP_MAG: d = s.bufv[4];
            ADDR_RESP_PHASE: d = s.bufv[5];
            ADDR_LEAD_OFF: d = s.bufv[6];
            ADDR_CRC: d = s.bufv[8];
            default: d = 24'h000000;
        endcase
        return d;
    endfunction : rd_reg
    // Edge detection between the second and third clock synchroniser stages
    assign ck_rise = s_q.ck_s2 && !s_q.ck_s3 && !s_q.cs_s2;
    assign ck_fall = !s_q.ck_s2 && s_q.ck_s3 && !s_q.cs_s2;
    assign rx_word = {s_q.rx[30:0], s_q.di_s2};
    assign word_end = ck_rise && s_q.rcnt == s_q.wlen - 6'h01;
    assign r128 = s_q.frm[FRM_RATE_LSB +: 2] == RATE_128K;
    assign hs_need = s_q.ctl[CTL_SPEED_BIT] ? HS_HP_CYC : HS_LP_CYC;
    // Next-state logic for the whole block
    always_comb begin
        logic [4:0] ns;
        logic [3:0] w;
        logic [23:0] d;
        logic [9:0] omit;
        s_d = s_q;
        ns = 5'h00;
        w = 4'h0;
        d = 24'h000000;
        omit = s_q.frm[FRM_OMIT_LSB +: 10] & 10'h3fe;
        // Synchronisers for all pins: two stages for select and data, three for the clock
        s_d.cs_s1 = spi_cs_n;
        s_d.cs_s2 = s_q.cs_s1;
        s_d.ck_s1 = spi_sclk;
        s_d.ck_s2 = s_q.ck_s1;
        s_d.ck_s3 = s_q.ck_s2;
        s_d.di_s1 = spi_sdi;
        s_d.di_s2 = s_q.di_s1;
        // Start-up busy period
        if (!s_q.init_done) begin
            s_d.init_cnt = s_q.init_cnt + 7'h01;
            s_d.init_done = s_q.init_cnt == INIT_CYC - 7'h01;
        end
        // Buffer fill with frame skipping
        if (frame_load && s_q.ctl[CTL_CNV_BIT]) begin
            if (s_q.skip_cnt == 4'h0) begin
                s_d.skip_cnt = s_q.frm[FRM_SKIP_LSB +: 4];
                if (!s_q.full) begin
                    s_d.full = 1'b1;
                    s_d.bufv = {checksum_data, s_q.gpio, lead_off_data, resp_phase_data,
                                resp_mag_data, pace_data, ecg_ch3_data, ecg_ch2_data,
                                ecg_ch1_data};
                end
            end else begin
                s_d.skip_cnt = s_q.skip_cnt - 4'h1;
            end
        end
        if (s_q.cs_s2) begin
            // Deselected: word framing restarts at the next select
            s_d.rcnt = 6'h00;
            s_d.fcnt = 6'h00;
            s_d.tx_act = 1'b0;
            if (s_q.wr_req) begin
                s_d.wr_arm = 1'b1;
            end
        end else begin
            if (ck_fall) begin
                if (s_q.fcnt == 6'h00) begin
                    // Word start: pick what to send
                    s_d.tx_act = 1'b1;
                    s_d.fcnt = 6'h01;
                    s_d.wlen = WLEN_CMD;
                    s_d.tx = 32'h00000000;
                    if (s_q.wr_req) begin
                        s_d.wr_arm = 1'b1;
                    end
                    if (s_q.resp_pend) begin
                        s_d.tx = s_q.resp;
                        s_d.resp_pend = 1'b0;
                    end else if (s_q.framing) begin
                        s_d.wlen = r128 ? WLEN_FAST : WLEN_CMD;
                        ns = next_slot(s_q.pos, r128, omit);
                        if (s_q.frm[FRM_RPT_BIT] && !s_q.full && s_q.pos == 4'h0) begin
                            ns = 5'h10;
                        end else begin
                            s_d.pos = ns[3:0] + 4'h1;
                            s_d.last = !next_slot(ns[3:0] + 4'h1, r128, omit)[4];
                        end
                        w = slot_word(ns[3:0], r128);
                        d = word_data(s_q, w);
                        if (!ns[4]) begin
                            s_d.tx = 32'h00000000;
                        end else if (!r128) begin
                            s_d.tx = {1'b0, word_addr(w), d};
                        end else if (slot_word(ns[3:0] - 4'h1, r128) == w) begin
                            s_d.tx = {d[7:0], 24'h000000};
                        end else begin
                            s_d.tx = {d[23:8], 16'h0000};
                        end
                    end
                end else begin
                    s_d.tx = {s_q.tx[30:0], 1'b0};
                    if (s_q.fcnt == s_q.wlen - 6'h01) begin
                        s_d.fcnt = 6'h00;
                        if (s_q.last && s_q.framing) begin
                            s_d.full = 1'b0;
                            s_d.last = 1'b0;
                            s_d.pos = 4'h0;
                        end
                    end else begin
                        s_d.fcnt = s_q.fcnt + 6'h01;
                    end
                end
            end
            if (ck_rise) begin
                s_d.rx = rx_word;
                s_d.rcnt = word_end ? 6'h00 : s_q.rcnt + 6'h01;
            end
            if (word_end && s_q.wlen == WLEN_FAST) begin
                if (rx_word[15:0] != 16'h0000) begin
                    s_d.framing = 1'b0;
                end
            end else if (word_end && rx_word[CMD_RW_BIT]) begin
                s_d.wr_req = 1'b1;
                s_d.wr_arm = 1'b0;
                s_d.hs_cnt = 7'h00;
                s_d.wr_addr = rx_word[30:24];
                s_d.wr_data = rx_word[23:0];
                if (rx_word[30:24] != ADDR_NOP) begin
                    s_d.framing = 1'b0;
                end
            end else if (word_end) begin
                if (rx_word[30:24] == ADDR_HDR) begin
                    s_d.framing = 1'b1;
                    s_d.pos = 4'h0;
                    s_d.last = 1'b0;
                end else if (!(rx_word[30:24] == ADDR_NOP && s_q.framing)) begin
                    s_d.framing = 1'b0;
                    s_d.resp_pend = 1'b1;
                    s_d.resp = {1'b0, rx_word[30:24], rd_reg(s_q, rx_word[30:24])};
                end
            end
        end
        // Held write crosses after the handshake time and the word boundary
        if (s_q.wr_req) begin
            if (s_q.hs_cnt < hs_need) begin
                s_d.hs_cnt = s_q.hs_cnt + 7'h01;
            end else if (s_q.wr_arm) begin
                s_d.wr_req = 1'b0;
                s_d.wr_arm = 1'b0;
                s_d.hs_cnt = 7'h00;
                case (s_q.wr_addr)
                    ADDR_CTL: s_d.ctl = s_q.wr_data;
                    ADDR_FRM: s_d.frm = s_q.wr_data;
                    ADDR_GPIO: s_d.gpio = s_q.wr_data;
                    default: s_d.ctl = s_q.ctl;
                endcase
            end
        end
        // Registered pin values
        s_d.rdy_n = !s_d.init_done || (s_d.ctl[CTL_CNV_BIT] && !s_d.full);
        s_d.sdo = s_d.tx_act ? s_d.tx[31] : s_d.rdy_n;
        s_d.sdo_oe = !s_d.cs_s2;
    end

    // State register; select and clock idle high
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.cs_s1 <= 1'b1;
            s_q.cs_s2 <= 1'b1;
            s_q.ck_s1 <= 1'b1;
            s_q.ck_s2 <= 1'b1;
            s_q.ck_s3 <= 1'b1;
            s_q.ctl <= CTL_RST;
            s_q.frm <= FRM_RST;
            s_q.gpio <= GPIO_RST;
            s_q.wlen <= WLEN_CMD;
            s_q.rdy_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign spi_sdo = s_q.sdo;
    assign spi_sdo_oe = s_q.sdo_oe;
    assign frame_ready_n = s_q.rdy_n;
    assign conversion_enable = s_q.ctl[CTL_CNV_BIT];
    // Checks on the running block
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_init_busy: assert property (!s_q.init_done |-> s_q.rdy_n)
        else $error("ready low during start-up");
    a_init_length: assert property ($rose(s_q.init_done) |-> $past(s_q.init_cnt) == 7'h3f)
        else $error("start-up length wrong");
    a_ready_level: assert property (s_q.init_done && s_q.ctl[CTL_CNV_BIT]
        |-> s_q.rdy_n == !s_q.full)
        else $error("ready does not follow buffer");
    a_ready_idle: assert property (s_q.init_done && !s_q.ctl[CTL_CNV_BIT] |-> !s_q.rdy_n)
        else $error("ready high without conversions");
    a_sdo_status: assert property (!s_q.cs_s2 && !s_q.tx_act |-> s_q.sdo == s_q.rdy_n)
        else $error("idle output not showing ready");
    a_oe_select: assert property (s_q.cs_s2 |-> !spi_sdo_oe)
        else $error("output driven while deselected");
    a_read_reply: assert property (word_end && s_q.wlen == WLEN_CMD && !rx_word[31]
        && rx_word[30:24] != ADDR_HDR && rx_word[30:24] != ADDR_NOP
        |=> s_q.resp_pend && !s_q.framing ##1 !s_q.framing)
        else $error("read reply not queued");
    a_header_start: assert property (word_end && s_q.wlen == WLEN_CMD
        && rx_word[31:24] == 8'h40 |=> s_q.framing && s_q.pos == 4'h0)
        else $error("header read did not start frames");
    a_nop_keeps: assert property (word_end && s_q.framing && rx_word == 32'h00000000
        |=> s_q.framing)
        else $error("zero word stopped frames");
    a_fast_width: assert property (ck_fall && s_q.fcnt == 6'h00 && !s_q.resp_pend
        && s_q.framing && r128 |=> s_q.wlen == 6'h10)
        else $error("fast frame word not 16 bits");
    a_write_wait: assert property ($fell(s_q.wr_req) |-> $past(s_q.hs_cnt) == $past(hs_need)
        && $past(s_q.hs_cnt) >= 7'd30)
        else $error("write applied before handshake");
    a_full_drop: assert property (ck_fall && s_q.framing && s_q.last
        && s_q.fcnt == s_q.wlen - 6'h01 |=> !s_q.full)
        else $error("buffer not freed after last bit");
    c_frame_start: cover property (word_end && rx_word[31:24] == 8'h40);
    c_frame_done: cover property ($fell(s_q.full));
    c_read_reply: cover property ($fell(s_q.resp_pend));
    c_fast_frame: cover property (s_q.framing && s_q.wlen == WLEN_FAST);

endmodule : ecg_frame_spi_readout

//--- testbench/ecg_host_model.sv
// Host serial master model for the frame readout block, clock mode 3
`timescale 1ns/100ps
module ecg_host_model (
    input wire logic core_clk,
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_sdi,
    input wire logic sdo_line
);
    localparam int HALF_NS = 200;

    // Idle: deselected with the clock parked high
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b1;
        spi_sdi = 1'b0;
    end

    // One word MSB first; select stays low afterwards when keep is set
    task automatic word(input logic [31:0] tx, input int nbits, input bit keep,
                        output logic [31:0] rx);
        rx = '0;
        if (spi_cs_n) begin
            @(posedge core_clk);
            #2 spi_cs_n = 1'b0;
            #HALF_NS;
        end
        // Drive on falling edges, sample on rising edges
        for (int i = 31; i > 31 - nbits; i--) begin
            spi_sclk = 1'b0;
            spi_sdi = tx[i];
            #HALF_NS spi_sclk = 1'b1;
            rx = {rx[30:0], sdo_line};
            #HALF_NS;
        end
        // Gap long enough for the slow crossing handshake
        if (!keep) begin
            spi_cs_n = 1'b1;
            spi_sdi = ~spi_sdi;
            #4000;
        end
    endtask : word

    // Select without clocking and look at the data line
    task automatic peek(output logic lvl);
        @(posedge core_clk);
        #2 spi_cs_n = 1'b0;
        #1000 lvl = sdo_line;
        spi_cs_n = 1'b1;
        #4000;
    endtask : peek
endmodule : ecg_host_model

//--- testbench/ecg_frame_spi_readout_tb_top.sv
// Self-checking bench for the ECG frame serial readout block
`timescale 1ns/100ps
module ecg_frame_spi_readout_tb_top;
    import ecg_spi_pkg::*;
    typedef struct packed {logic [31:0] wr; logic [31:0] rd; logic [31:0] exp;} row_t;
    localparam logic [23:0] GPIO_V = 24'ha5c3e1;
    localparam row_t ROWS [5] = '{
        '{32'h86a5c3e1, 32'h06000000, 32'h06a5c3e1},
        '{32'h80ffffff, 32'h06000000, 32'h06a5c3e1},
        '{32'h8a7fc04f, 32'h0a000000, 32'h0a7fc04f},
        '{32'h8a000000, 32'h0a000000, 32'h0a000000},
        '{32'h8100000c, 32'h01000000, 32'h0100000c}};
    localparam logic [6:0] ADDR_L [10] = '{ADDR_HDR, ADDR_CH1, ADDR_CH2, ADDR_CH3,
        ADDR_PACE, ADDR_RESP_MAG, ADDR_RESP_PHASE, ADDR_LEAD_OFF, ADDR_GPIO, ADDR_CRC};
    localparam int SLOT16 [13] = '{0, 1, 2, 3, 4, 4, 5, 5, 6, 6, 7, 8, 9};
    logic core_clk, rst, frame_load, sdo_last, sdo_line, lvl;
    logic spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe, frame_ready_n, conversion_enable;
    logic [23:0] vals [8];
    logic [31:0] rx;
    int compares = 0;
    int miscompares = 0;

    ecg_frame_spi_readout i_dut (.core_clk(core_clk), .rst(rst), .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
        .frame_ready_n(frame_ready_n), .conversion_enable(conversion_enable),
        .frame_load(frame_load), .ecg_ch1_data(vals[0]), .ecg_ch2_data(vals[1]),
        .ecg_ch3_data(vals[2]), .pace_data(vals[3]), .resp_mag_data(vals[4]),
        .resp_phase_data(vals[5]), .lead_off_data(vals[6]), .checksum_data(vals[7]));
    ecg_host_model i_host (.core_clk(core_clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
        .spi_sdi(spi_sdi), .sdo_line(sdo_line));

    // Released data line does not keep its last level
    always @(posedge core_clk) if (spi_sdo_oe === 1'b1) sdo_last <= spi_sdo;
    assign sdo_line = (spi_sdo_oe === 1'b1) ? spi_sdo : ~sdo_last;

    // Clock generator
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("counts: compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim

    // Bounded wait for the ready output to reach a level
    task automatic wait_level(input logic want, input int max);
        for (int i = 0; i < max && frame_ready_n !== want; i++) begin
            @(posedge core_clk);
            #1;
        end
        check({31'h0, frame_ready_n}, {31'h0, want});
        if (frame_ready_n !== want) end_sim();
    endtask : wait_level

    task automatic load_frame();
        @(posedge core_clk);
        #2 frame_load = 1'b1;
        @(posedge core_clk);
        #2 frame_load = 1'b0;
    endtask : load_frame

    // Payload of frame slot k as the 32-bit format carries it
    function automatic logic [23:0] slot_data(input int k);
        if (k == 0) return 24'(1) << HDR_READY_BIT;
        if (k == 8) return GPIO_V;
        return (k == 9) ? vals[7] : vals[k - 1];
    endfunction : slot_data

    function automatic logic [31:0] exp16(input int k);
        logic [23:0] d;
        d = slot_data(SLOT16[k]);
        if (k == 5 || k == 7 || k == 9) return {16'h0, d[7:0], 8'h00};
        return {16'h0, d[23:8]};
    endfunction : exp16

    // Header read, then zero words; last word carries last_tx and deselects
    task automatic run_frame(input bit fast, input logic [31:0] last_tx);
        int n;
        n = fast ? 13 : 10;
        i_host.word(32'h40000000, 32, 1'b1, rx);
        for (int k = 0; k < n; k++) begin
            i_host.word((k == n - 1) ? last_tx : 32'h0, fast ? 16 : 32, k != n - 1, rx);
            check(rx, fast ? exp16(k) : {1'b0, ADDR_L[k], slot_data(k)});
        end
    endtask : run_frame

    // Main sequence
    initial begin
        rst = 1'b1;
        frame_load = 1'b0;
        vals = '{24'h123456, 24'h234567, 24'h345678, 24'h456789,
                 24'h56789a, 24'h6789ab, 24'h789abc, 24'h89abcd};
        repeat (3) @(posedge core_clk);
        check({29'h0, frame_ready_n, spi_sdo_oe, conversion_enable}, 32'h4);
        repeat (3) @(posedge core_clk);
        #2 rst = 1'b0;
        repeat (50) @(posedge core_clk);
        check({31'h0, frame_ready_n}, 32'h1);
        wait_level(1'b0, 30);
        $display("test reset done");
        // Register table: write, read, then collect reply in the next word
        foreach (ROWS[r]) begin
            i_host.word(ROWS[r].wr, 32, 1'b0, rx);
            i_host.word(ROWS[r].rd, 32, 1'b0, rx);
            i_host.word(32'h0, 32, 1'b0, rx);
            check(rx, ROWS[r].exp);
        end
        check({31'h0, conversion_enable}, 32'h1);
        wait_level(1'b1, 10);
        $display("test registers done");
        // 32-bit frame with a register read in its last word
        load_frame();
        wait_level(1'b0, 20);
        i_host.peek(lvl);
        check({31'h0, lvl}, 32'h0);
        run_frame(1'b0, 32'h06000000);
        wait_level(1'b1, 20);
        i_host.word(32'h0, 32, 1'b1, rx);
        check(rx, {8'h06, GPIO_V});
        i_host.word(32'h0, 32, 1'b0, rx);
        check(rx, 32'h0);
        check({31'h0, spi_sdo_oe}, 32'h0);
        i_host.peek(lvl);
        check({31'h0, lvl}, 32'h1);
        $display("test frame32 done");
        // 16-bit frame at the fast rate with fresh values
        i_host.word(32'h8a000020, 32, 1'b0, rx);
        foreach (vals[i]) vals[i] = ~vals[i];
        load_frame();
        wait_level(1'b0, 20);
        run_frame(1'b1, 32'h0);
        wait_level(1'b1, 20);
        $display("test frame16 done");
        // A nonzero short word ends fast framing, then skip one load in two with header repeat
        i_host.word(32'hffff0000, 16, 1'b0, rx);
        i_host.word(32'h8a000041, 32, 1'b0, rx);
        load_frame();
        wait_level(1'b0, 20);
        run_frame(1'b0, 32'h0);
        load_frame();
        repeat (5) @(posedge core_clk);
        #1 check({31'h0, frame_ready_n}, 32'h1);
        i_host.word(32'h0, 32, 1'b1, rx);
        check(rx, {1'b0, ADDR_HDR, 24'h000000});
        load_frame();
        wait_level(1'b0, 20);
        i_host.word(32'h0, 32, 1'b0, rx);
        check(rx, {1'b0, ADDR_HDR, slot_data(0)});
        $display("test skip done");
        end_sim();
    end
endmodule : ecg_frame_spi_readout_tb_top
